// *** pkg/cts_defs.svh ***
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
// Purpose: offsets, bit positions, codes and reset values
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: included by the syndrome encoder

// APB register byte offsets
`define CTS_OFF_CTRL 12'h000
`define CTS_OFF_STAT 12'h004
`define CTS_OFF_SYN 12'h008
// Trap control bits
`define CTS_B_TMR 0
`define CTS_B_PMU 4
`define CTS_B_AMU 5
`define CTS_B_VMR 6
`define CTS_B_VMW 7
`define CTS_B_TLB 8
`define CTS_B_SETW 9
`define CTS_B_POC 10
`define CTS_B_POU 11
`define CTS_B_FAC 12
`define CTS_B_TR1 13
`define CTS_B_TR2 14
`define CTS_B_TR3 15
`define CTS_B_DBG1 16
`define CTS_B_FINE 17
`define CTS_B_DBG2 18
`define CTS_B_DBG3 19
`define CTS_B_PD2 20
`define CTS_B_PD3 21
`define CTS_B_ID0 22
`define CTS_B_ID3 23
`define CTS_B_VLEN 24
`define CTS_CTRL_W 25
`define CTS_CTRL_RST 25'h000003f
// Status bits
`define CTS_ST_CAP 0
`define CTS_ST_EL 1
`define CTS_ST_XC 8
// Exception class codes
`define CTS_XC_CP15 6'h03
`define CTS_XC_CP14 6'h05
`define CTS_XC_FPID 6'h08
`define CTS_XC_PR15 6'h04
`define CTS_XC_PR14 6'h0c
// Coprocessor numbers and levels
`define CTS_CP15 4'hf
`define CTS_CP14 4'he
`define CTS_EL0 2'h0
`define CTS_EL1 2'h1
`define CTS_EL2 2'h2
`define CTS_EL3 2'h3
// Syndrome fields
`define CTS_SYN_W 25
`define CTS_SYN_VALID 24
`define CTS_CONDITION_CODE_FIELD_ALWAYS 4'he
`define CTS_OPND_FP 4'h0
`define CTS_AT_STV 25'h0000000
`define CTS_AT_STV0 25'h0000001
`define CTS_AT_LDST 25'h0000002
`endif

// *** pkg/cts_pkg.sv ***
// Purpose: types shared by the syndrome encoder
// Assumes: nothing
// Notes: state codes are one-hot
package cts_pkg;
  // Trapped instruction kind
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CP_WR = 4'h1, OP_CP_RD = 4'h2, OP_FP_RD = 4'h3,
    OP_PAIR_WR = 4'h4, OP_PAIR_RD = 4'h5, OP_AT_STV = 4'h6,
    OP_AT_STV0 = 4'h7, OP_AT_LDST = 4'h8
  } cts_op_t;
  // Target register group of the access
  typedef enum logic [3:0] {
    CL_OTHER = 4'h0, CL_TIMER = 4'h1, CL_PERF = 4'h2, CL_ACT = 4'h3,
    CL_VMCTL = 4'h4, CL_TLB = 4'h5, CL_SETWAY = 4'h6, CL_POC = 4'h7,
    CL_POU = 4'h8, CL_FEAT = 4'h9, CL_TRACE = 4'ha, CL_DBGCH = 4'hb,
    CL_PDBG = 4'hc, CL_JAZID = 4'hd, CL_FPID = 4'he, CL_IDG3 = 4'hf
  } cts_cls_t;
  // APB slave states
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACC = 2'b10} cts_apb_st_t;
endpackage : cts_pkg

// *** hdl/cts_top.sv ***
// Purpose: coprocessor trap check and syndrome capture
// Assumes: decode inputs synchronous to pclk, valid with trap_req
// Notes: trap controls and captured syndrome reached over APB
// Contract
// - Second operand goes to syndrome bits 4:1
// - Floating-point ID read reports zero operand
// - Bit 0 is direction, one means read
// - Syndrome fields need no defined reset value
// - Trapped coprocessor 15 single access uses class 03
// - Timer access from level 0 traps when denied
// - Perf monitor level-0 access traps when disabled
// - Activity monitor level-0 access traps when disabled
// - Level-1 virtual memory control access traps
// - Level-1 TLB maintenance traps to level 2
// - Cache maintenance traps on set/way, coherency, unification
// - Feature access control access traps to level 3
// - Trapped coprocessor 14 single access uses class 05
// - Debug channel access traps, finer with feature
// - Powerdown debug access traps to level 2/3
// - Jazelle ID read traps on group-0 control
// - FP system ID read traps, class 08
// - FP group-3 ID reads trap to level 2
// - Block atomic syndrome encodes 0, 1, 2
// - No other block atomic syndrome value
// - Bit 24 marks condition field valid
// - From 64-bit state validity bit is one
// - Fixed-length one; variable-length set by control
//
// Design decisions made here: the address map and register access over APB.
`include "cts_defs.svh"

module cts_top #(
  parameter logic [5:0] EXC_CLASS_ATOMIC = 6'h0a // Class for block atomics
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic trap_req, // Instruction at commit point
  input wire cts_pkg::cts_op_t trap_op, // Instruction kind
  input wire logic [3:0] coproc_num, // Coprocessor number
  input wire logic [1:0] cur_el, // Current level
  input wire logic state_32, // 32-bit execution state
  input wire logic fixed_len, // Fixed-length encoding
  input wire logic hyp_route, // Level-0 traps go to level 2
  input wire cts_pkg::cts_cls_t reg_class, // Register group
  input wire logic [1:0] timer_sel, // Timer enable index
  input wire logic [3:0] instr_condition, // Instruction condition
  input wire logic [14:0] instr_fields, // Syndrome bits 19:5
  input wire logic [3:0] second_coproc_operand, // Second operand
  input wire logic ext_trap, // Trap found elsewhere
  input wire logic [1:0] ext_target_el, // Its target level
  output logic exc_taken_q, // Exception entry pulse
  output logic [1:0] exc_target_el_q, // Target level
  output logic [5:0] exception_class_code_q, // Exception class
  output logic [24:0] instruction_specific_syndrome_q // Syndrome
);
  import cts_pkg::*;

  // ----------------------------------------
  // Trap decision
  // ----------------------------------------
  logic [`CTS_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic hit;
  logic [1:0] tgt;
  logic [1:0] route;
  logic single;
  logic lo;
  logic [5:0] xcls;
  logic [`CTS_SYN_W-1:0] syn;
  logic valid_bit;
  logic [3:0] cc;
  logic [3:0] opnd;

  // Level checks per register group
  always_comb begin : trap_decide
    route = hyp_route ? `CTS_EL2 : `CTS_EL1;
    single = (trap_op == OP_CP_WR) || (trap_op == OP_CP_RD);
    lo = (cur_el == `CTS_EL0) || (cur_el == `CTS_EL1);
    hit = 1'b0;
    tgt = `CTS_EL1;
    if (single && coproc_num == `CTS_CP15 && state_32) begin
      unique case (reg_class)
        CL_TIMER: if (cur_el == `CTS_EL0 && !ctrl_q[`CTS_B_TMR + timer_sel]) begin
          hit = 1'b1;
          tgt = route;
        end
        CL_PERF: if (cur_el == `CTS_EL0 && !ctrl_q[`CTS_B_PMU]) begin
          hit = 1'b1;
          tgt = route;
        end
        CL_ACT: if (cur_el == `CTS_EL0 && !ctrl_q[`CTS_B_AMU]) begin
          hit = 1'b1;
          tgt = route;
        end
        CL_VMCTL: if (cur_el == `CTS_EL1 &&
                      (trap_op == OP_CP_RD ? ctrl_q[`CTS_B_VMR] : ctrl_q[`CTS_B_VMW])) begin
          hit = 1'b1;
          tgt = `CTS_EL2;
        end
        CL_TLB: if (cur_el == `CTS_EL1 && ctrl_q[`CTS_B_TLB]) begin
          hit = 1'b1;
          tgt = `CTS_EL2;
        end
        CL_SETWAY, CL_POC, CL_POU: begin
          if (lo && ((reg_class == CL_SETWAY && ctrl_q[`CTS_B_SETW]) ||
                     (reg_class == CL_POC && ctrl_q[`CTS_B_POC]) ||
                     (reg_class == CL_POU && ctrl_q[`CTS_B_POU]))) begin
            hit = 1'b1;
            tgt = `CTS_EL2;
          end
        end
        CL_FEAT: if ((cur_el == `CTS_EL1 || cur_el == `CTS_EL2) && ctrl_q[`CTS_B_FAC]) begin
          hit = 1'b1;
          tgt = `CTS_EL3;
        end
        default: hit = 1'b0;
      endcase
    end else if (single && coproc_num == `CTS_CP14) begin
      unique case (reg_class)
        CL_TRACE: begin
          if (lo && ctrl_q[`CTS_B_TR1]) begin
            hit = 1'b1;
            tgt = route;
          end else if (cur_el != `CTS_EL3 && ctrl_q[`CTS_B_TR2]) begin
            hit = 1'b1;
            tgt = `CTS_EL2;
          end else if (ctrl_q[`CTS_B_TR3]) begin
            hit = 1'b1;
            tgt = `CTS_EL3;
          end
        end
        CL_DBGCH: begin
          if (lo && ctrl_q[`CTS_B_DBG1]) begin
            hit = 1'b1;
            tgt = route;
          end else if (ctrl_q[`CTS_B_FINE] && lo && ctrl_q[`CTS_B_DBG2]) begin
            hit = 1'b1;
            tgt = `CTS_EL2;
          end else if (ctrl_q[`CTS_B_FINE] && cur_el != `CTS_EL3 &&
                       ctrl_q[`CTS_B_DBG3]) begin
            hit = 1'b1;
            tgt = `CTS_EL3;
          end
        end
        CL_PDBG: if (state_32) begin
          if (cur_el != `CTS_EL3 && ctrl_q[`CTS_B_PD2]) begin
            hit = 1'b1;
            tgt = `CTS_EL2;
          end else if (ctrl_q[`CTS_B_PD3]) begin
            hit = 1'b1;
            tgt = `CTS_EL3;
          end
        end
        CL_JAZID: if (trap_op == OP_CP_RD && lo && ctrl_q[`CTS_B_ID0]) begin
          hit = 1'b1;
          tgt = `CTS_EL2;
        end
        default: hit = 1'b0;
      endcase
    end else if (trap_op == OP_FP_RD) begin
      // FP system ID at level 1
      if (reg_class == CL_FPID && cur_el == `CTS_EL1 && ctrl_q[`CTS_B_ID0]) begin
        hit = 1'b1;
        tgt = `CTS_EL2;
      end else if (reg_class == CL_IDG3 && lo && ctrl_q[`CTS_B_ID3]) begin
        hit = 1'b1;
        tgt = `CTS_EL2;
      end
    end
    if (!hit && ext_trap && trap_op != OP_NONE) begin
      hit = 1'b1;
      tgt = ext_target_el;
    end
  end

  // ----------------------------------------
  // Class and syndrome
  // ----------------------------------------
  // Build class and syndrome for the trapping instruction
  always_comb begin : syn_build
    valid_bit = !state_32 || fixed_len || ctrl_q[`CTS_B_VLEN];
    cc = state_32 ? instr_condition : `CTS_CONDITION_CODE_FIELD_ALWAYS;
    opnd = (trap_op == OP_FP_RD) ? `CTS_OPND_FP : second_coproc_operand;
    xcls = 6'h00;
    syn = '0;
    unique case (trap_op)
      OP_CP_WR, OP_CP_RD, OP_FP_RD: begin
        syn = {valid_bit, cc, instr_fields, opnd, trap_op != OP_CP_WR};
        xcls = (trap_op == OP_FP_RD) ? `CTS_XC_FPID :
               (coproc_num == `CTS_CP14) ? `CTS_XC_CP14 : `CTS_XC_CP15;
      end
      OP_PAIR_WR, OP_PAIR_RD: begin
        syn = {valid_bit, 24'h000000};
        xcls = (coproc_num == `CTS_CP14) ? `CTS_XC_PR14 : `CTS_XC_PR15;
      end
      OP_AT_STV: begin
        syn = `CTS_AT_STV;
        xcls = EXC_CLASS_ATOMIC;
      end
      OP_AT_STV0: begin
        syn = `CTS_AT_STV0;
        xcls = EXC_CLASS_ATOMIC;
      end
      OP_AT_LDST: begin
        syn = `CTS_AT_LDST;
        xcls = EXC_CLASS_ATOMIC;
      end
      OP_NONE: syn = '0;
      default: syn = '0;
    endcase
  end

  // ----------------------------------------
  // Capture on exception entry
  // ----------------------------------------
  logic taken_d;
  logic [1:0] el_d;
  logic [5:0] xc_d;
  logic [`CTS_SYN_W-1:0] syn_d;
  logic cap_q, cap_d;
  logic wr_acc;

  always_comb begin : cap_next
    taken_d = trap_req && hit;
    el_d = exc_target_el_q;
    xc_d = exception_class_code_q;
    syn_d = instruction_specific_syndrome_q;
    cap_d = cap_q;
    if (wr_acc && paddr == `CTS_OFF_STAT && pwdata[`CTS_ST_CAP]) begin
      cap_d = 1'b0;
    end
    if (taken_d) begin
      el_d = tgt;
      xc_d = xcls;
      syn_d = syn;
      cap_d = 1'b1;
    end
  end

  // reset value is a convenience only
  always_ff @(posedge pclk or negedge presetn) begin : cap_regs
    if (!presetn) begin
      exc_taken_q <= 1'b0;
      exc_target_el_q <= `CTS_EL0;
      exception_class_code_q <= 6'h00;
      instruction_specific_syndrome_q <= '0;
      cap_q <= 1'b0;
    end else begin
      exc_taken_q <= taken_d;
      exc_target_el_q <= el_d;
      exception_class_code_q <= xc_d;
      instruction_specific_syndrome_q <= syn_d;
      cap_q <= cap_d;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  cts_apb_st_t st_q, st_d;
  logic [31:0] rd_d;
  logic rdy_d;
  logic err_d;
  logic mapped;

  assign wr_acc = (st_q == ST_ACC) && psel && penable && pwrite;
  assign mapped = (paddr == `CTS_OFF_CTRL) || (paddr == `CTS_OFF_STAT) ||
                  (paddr == `CTS_OFF_SYN);

  // Decode, read mux and control writes
  always_comb begin : apb_next
    st_d = st_q;
    rd_d = prdata;
    rdy_d = 1'b0;
    err_d = 1'b0;
    ctrl_d = ctrl_q;
    unique case (st_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          st_d = ST_ACC;
          rdy_d = 1'b1;
          err_d = !mapped;
          rd_d = 32'h00000000;
          if (!pwrite && paddr == `CTS_OFF_CTRL) begin
            rd_d = {7'h00, ctrl_q};
          end else if (!pwrite && paddr == `CTS_OFF_STAT) begin
            rd_d[`CTS_ST_CAP] = cap_q;
            rd_d[`CTS_ST_EL +: 2] = exc_target_el_q;
            rd_d[`CTS_ST_XC +: 6] = exception_class_code_q;
          end else if (!pwrite && paddr == `CTS_OFF_SYN) begin
            rd_d = {7'h00, instruction_specific_syndrome_q};
          end
        end
      end
      ST_ACC: begin
        st_d = ST_IDLE;
        if (wr_acc && paddr == `CTS_OFF_CTRL) begin
          ctrl_d = pwdata[`CTS_CTRL_W-1:0];
        end
      end
    endcase
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin : apb_regs
    if (!presetn) begin
      st_q <= ST_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_q <= `CTS_CTRL_RST;
    end else begin
      st_q <= st_d;
      prdata <= rd_d;
      pready <= rdy_d;
      pslverr <= err_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_operand_copy: assert property (
    trap_req && hit && trap_op == OP_CP_WR |=> exc_taken_q &&
    instruction_specific_syndrome_q[4:0] == {$past(second_coproc_operand), 1'b0})
    else $error("operand or direction wrong for write");
  a_fp_zero_read: assert property (
    trap_req && hit && trap_op == OP_FP_RD |=>
    instruction_specific_syndrome_q[4:0] == 5'h01 &&
    exception_class_code_q == `CTS_XC_FPID)
    else $error("FP read syndrome wrong");
  a_cp15_class: assert property (
    trap_req && hit && trap_op == OP_CP_RD && coproc_num == `CTS_CP15 |=>
    exception_class_code_q == `CTS_XC_CP15 && instruction_specific_syndrome_q[0])
    else $error("class 03 missing");
  a_tlb_target: assert property (
    trap_req && single && coproc_num == `CTS_CP15 && state_32 &&
    cur_el == `CTS_EL1 && reg_class == CL_TLB && ctrl_q[`CTS_B_TLB] |=>
    exc_taken_q && exc_target_el_q == `CTS_EL2)
    else $error("TLB trap not taken to level 2");
  a_feat_target: assert property (
    trap_req && single && coproc_num == `CTS_CP15 && state_32 &&
    cur_el == `CTS_EL2 && reg_class == CL_FEAT && ctrl_q[`CTS_B_FAC] |=>
    exc_taken_q && exc_target_el_q == `CTS_EL3)
    else $error("feature trap not taken to level 3");
  a_atomic_codes: assert property (
    exc_taken_q && exception_class_code_q == EXC_CLASS_ATOMIC |->
    instruction_specific_syndrome_q <= `CTS_AT_LDST)
    else $error("reserved atomic syndrome");
  a_valid_64bit: assert property (
    trap_req && hit && !state_32 && trap_op == OP_PAIR_RD |=>
    instruction_specific_syndrome_q[`CTS_SYN_VALID])
    else $error("validity bit clear from 64-bit state");
  a_syn_hold: assert property (
    !(trap_req && hit) |=> !exc_taken_q && $stable(instruction_specific_syndrome_q) &&
    $stable(exception_class_code_q) && $stable(exc_target_el_q))
    else $error("syndrome changed without entry");
  a_timer_deny: assert property (
    trap_req && single && coproc_num == `CTS_CP15 && state_32 && cur_el == `CTS_EL0 &&
    reg_class == CL_TIMER && !ctrl_q[`CTS_B_TMR + timer_sel] |=>
    exc_taken_q ##1 !exc_taken_q || $past(trap_req, 1))
    else $error("timer trap missed");

endmodule : cts_top

// *** dv/cts_pipe_model.sv ***
// Purpose: pipeline decode and trap-check stand-in for the encoder
// Assumes: commands arrive through the issue task
// Notes: condition, syndrome fields and second operand are scrambled outside the commit pulse
module cts_pipe_model (
  input wire logic pclk, // Core clock
  output logic trap_req, // Commit pulse
  output cts_pkg::cts_op_t trap_op, // Instruction kind
  output logic [3:0] coproc_num, // Coprocessor number
  output logic [1:0] cur_el, // Current level
  output logic state_32, // 32-bit state
  output logic fixed_len, // Fixed-length encoding
  output logic hyp_route, // Level-0 traps to level 2
  output cts_pkg::cts_cls_t reg_class, // Register group
  output logic [1:0] timer_sel, // Timer enable index
  output logic [3:0] instr_condition, // Condition
  output logic [14:0] instr_fields, // Syndrome bits 19:5
  output logic [3:0] second_coproc_operand, // Second operand
  output logic ext_trap, // Trap decided elsewhere
  output logic [1:0] ext_target_el // Its target level
);
  timeunit 1ns;
  timeprecision 1ns;
  import cts_pkg::*;

  // Idle values at time zero
  initial begin
    {trap_req, ext_trap, state_32, fixed_len, hyp_route} = 5'h00;
    {coproc_num, cur_el, timer_sel, ext_target_el} = 10'h000;
    trap_op = OP_NONE;
    reg_class = CL_OTHER;
    {instr_condition, instr_fields, second_coproc_operand} = 23'h5a5a5a;
  end

  // One commit pulse with all decode fields valid beside it
  task automatic issue(input cts_op_t op, input logic [3:0] cp, input logic [1:0] el,
                       input logic s32, input logic fix, input cts_cls_t cls, input logic ext,
                       input logic [1:0] xel, input logic hr, input logic [7:0] n);
    @(posedge pclk);
    trap_req <= 1'b1;
    trap_op <= op;
    coproc_num <= cp;
    cur_el <= el;
    state_32 <= s32;
    fixed_len <= fix;
    reg_class <= cls;
    ext_trap <= ext;
    ext_target_el <= xel;
    hyp_route <= hr;
    // Timer enable index follows the tag so several enables are exercised
    timer_sel <= n[1:0];
    instr_condition <= n[3:0];
    instr_fields <= {n, n[6:0]};
    second_coproc_operand <= ~n[3:0];
    @(posedge pclk);
    // Outside the pulse the fields no longer hold their value
    trap_req <= 1'b0;
    ext_trap <= 1'b0;
    trap_op <= OP_NONE;
    instr_condition <= ~n[3:0];
    instr_fields <= ~{n, n[6:0]};
    second_coproc_operand <= n[3:0];
  endtask : issue
endmodule : cts_pipe_model

// *** dv/cts_top_bench.sv ***
// Purpose: self-checking bench for the syndrome encoder
// Assumes: zero-wait APB slave, one-cycle trap answer
// Notes: trap controls set through the control register
`include "cts_defs.svh"
module cts_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cts_pkg::*;
  localparam logic [5:0] XC_AT = 6'h0a;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, hr_b, exc_taken_q;
  logic [1:0] exc_target_el_q;
  logic [5:0] exception_class_code_q;
  logic [24:0] instruction_specific_syndrome_q, exp_q;
  logic [7:0] n;
  int miscompares, cmp_count;
  wire logic trap_req, state_32, fixed_len, hyp_route, ext_trap;
  wire cts_op_t trap_op;
  wire cts_cls_t reg_class;
  wire logic [3:0] coproc_num, instr_condition, second_coproc_operand;
  wire logic [1:0] cur_el, timer_sel, ext_target_el;
  wire logic [14:0] instr_fields;

  cts_pipe_model pm (.pclk(pclk), .trap_req(trap_req), .trap_op(trap_op),
    .coproc_num(coproc_num), .cur_el(cur_el), .state_32(state_32), .fixed_len(fixed_len),
    .hyp_route(hyp_route), .reg_class(reg_class), .timer_sel(timer_sel),
    .instr_condition(instr_condition), .instr_fields(instr_fields),
    .second_coproc_operand(second_coproc_operand), .ext_trap(ext_trap),
    .ext_target_el(ext_target_el));
  cts_top #(.EXC_CLASS_ATOMIC(XC_AT)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trap_req(trap_req), .trap_op(trap_op),
    .coproc_num(coproc_num), .cur_el(cur_el), .state_32(state_32), .fixed_len(fixed_len),
    .hyp_route(hyp_route), .reg_class(reg_class), .timer_sel(timer_sel),
    .instr_condition(instr_condition), .instr_fields(instr_fields),
    .second_coproc_operand(second_coproc_operand), .ext_trap(ext_trap),
    .ext_target_el(ext_target_el), .exc_taken_q(exc_taken_q),
    .exc_target_el_q(exc_target_el_q), .exception_class_code_q(exception_class_code_q),
    .instruction_specific_syndrome_q(instruction_specific_syndrome_q));

  // -----------------------------
  // Clock and closing
  // -----------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // APB transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Entry pulse, fields together, then pulse gone
  task automatic expect_trap(input logic [1:0] xel, input logic [5:0] xc,
                             input logic [24:0] syn);
    #1;
    chk("taken", 32'h1, {31'h0, exc_taken_q});
    chk("target", {30'h0, xel}, {30'h0, exc_target_el_q});
    chk("class", {26'h0, xc}, {26'h0, exception_class_code_q});
    chk("syndrome", {7'h0, syn}, {7'h0, instruction_specific_syndrome_q});
    exp_q = syn;
    @(posedge pclk);
    #1;
    chk("taken end", 32'h0, {31'h0, exc_taken_q});
  endtask : expect_trap

  // Internal trap from 32-bit fixed-length code
  task automatic trap_chk(input logic [31:0] ctl, input cts_op_t op, input logic [3:0] cp,
                          input logic [1:0] el, input cts_cls_t cls, input logic [1:0] xel,
                          input logic [5:0] xc);
    n = n + 8'h13;
    apb(1'b1, `CTS_OFF_CTRL, ctl);
    pm.issue(op, cp, el, 1'b1, 1'b1, cls, 1'b0, 2'h0, hr_b, n);
    expect_trap(xel, xc, {1'b1, n[3:0], n, n[6:0],
                (op == OP_FP_RD) ? `CTS_OPND_FP : ~n[3:0], op != OP_CP_WR});
  endtask : trap_chk

  initial begin
    #3_000_000;
    miscompares++;
    wrap_up();
  end

  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    {presetn, psel, penable, pwrite, hr_b} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    n = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTS_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000003f, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // Tag 13 selects timer enable 3, tag 26 selects enable 2; only that bit is clear
    trap_chk(32'h37, OP_CP_WR, `CTS_CP15, `CTS_EL0, CL_TIMER, 2'h1, `CTS_XC_CP15);
    hr_b = 1'b1;
    trap_chk(32'h3b, OP_CP_RD, `CTS_CP15, `CTS_EL0, CL_TIMER, 2'h2, `CTS_XC_CP15);
    hr_b = 1'b0;
    trap_chk(32'h2f, OP_CP_RD, `CTS_CP15, `CTS_EL0, CL_PERF, 2'h1, `CTS_XC_CP15);
    trap_chk(32'h1f, OP_CP_WR, `CTS_CP15, `CTS_EL0, CL_ACT, 2'h1, `CTS_XC_CP15);
    trap_chk(32'h7f, OP_CP_RD, `CTS_CP15, `CTS_EL1, CL_VMCTL, 2'h2, `CTS_XC_CP15);
    trap_chk(32'hbf, OP_CP_WR, `CTS_CP15, `CTS_EL1, CL_VMCTL, 2'h2, `CTS_XC_CP15);
    trap_chk(32'h13f, OP_CP_WR, `CTS_CP15, `CTS_EL1, CL_TLB, 2'h2, `CTS_XC_CP15);
    trap_chk(32'h23f, OP_CP_WR, `CTS_CP15, `CTS_EL1, CL_SETWAY, 2'h2, `CTS_XC_CP15);
    trap_chk(32'h43f, OP_CP_WR, `CTS_CP15, `CTS_EL0, CL_POC, 2'h2, `CTS_XC_CP15);
    trap_chk(32'h83f, OP_CP_WR, `CTS_CP15, `CTS_EL1, CL_POU, 2'h2, `CTS_XC_CP15);
    trap_chk(32'h103f, OP_CP_RD, `CTS_CP15, `CTS_EL2, CL_FEAT, 2'h3, `CTS_XC_CP15);
    trap_chk(32'h203f, OP_CP_RD, `CTS_CP14, `CTS_EL0, CL_TRACE, 2'h1, `CTS_XC_CP14);
    trap_chk(32'h1003f, OP_CP_WR, `CTS_CP14, `CTS_EL0, CL_DBGCH, 2'h1, `CTS_XC_CP14);
    trap_chk(32'h10003f, OP_CP_RD, `CTS_CP14, `CTS_EL1, CL_PDBG, 2'h2, `CTS_XC_CP14);
    trap_chk(32'h40003f, OP_CP_RD, `CTS_CP14, `CTS_EL0, CL_JAZID, 2'h2, `CTS_XC_CP14);
    trap_chk(32'h40003f, OP_FP_RD, `CTS_CP14, `CTS_EL1, CL_FPID, 2'h2, `CTS_XC_FPID);
    trap_chk(32'h80003f, OP_FP_RD, `CTS_CP14, `CTS_EL1, CL_IDG3, 2'h2, `CTS_XC_FPID);
    // Enabled timer access does not trap, syndrome kept
    apb(1'b1, `CTS_OFF_CTRL, 32'h3f);
    pm.issue(OP_CP_WR, `CTS_CP15, `CTS_EL0, 1'b1, 1'b1, CL_TIMER, 1'b0, 2'h0, 1'b0, 8'h77);
    #1;
    chk("no trap", 32'h0, {31'h0, exc_taken_q});
    apb(1'b1, `CTS_OFF_SYN, 32'h01ffffff);
    apb(1'b0, `CTS_OFF_SYN, 32'h0);
    chk("syn reg", {7'h0, exp_q}, rd);
    // Trap from 64-bit state
    pm.issue(OP_CP_RD, `CTS_CP15, `CTS_EL1, 1'b0, 1'b1, CL_OTHER, 1'b1, 2'h2, 1'b0, 8'h3c);
    expect_trap(2'h2, `CTS_XC_CP15, {1'b1, `CTS_CONDITION_CODE_FIELD_ALWAYS, 8'h3c, 7'h3c, 4'h3, 1'b1});
    // Variable-length validity bit follows control
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, `CTS_OFF_CTRL, {7'h0, v[0], 24'h3f});
      pm.issue(OP_CP_WR, `CTS_CP15, `CTS_EL0, 1'b1, 1'b0, CL_OTHER, 1'b1, 2'h1, 1'b0, 8'h21);
      #1;
      chk("valid bit", {31'h0, v[0]}, {31'h0, instruction_specific_syndrome_q[24]});
    end
    // Block atomic syndromes, all three codes
    for (int i = 0; i < 3; i++) begin
      pm.issue(cts_op_t'(4'h6 + i[3:0]), `CTS_CP15, `CTS_EL0, 1'b0, 1'b1, CL_OTHER, 1'b1,
               i[1:0] + 2'h1, 1'b0, 8'h5e);
      expect_trap(i[1:0] + 2'h1, XC_AT, 25'(i));
    end
    apb(1'b0, `CTS_OFF_STAT, 32'h0);
    chk("status", {18'h0, XC_AT, 5'h0, 2'h3, 1'b1}, rd);
    apb(1'b1, `CTS_OFF_STAT, 32'h1);
    apb(1'b0, `CTS_OFF_STAT, 32'h0);
    chk("status clear", 32'h0, {31'h0, rd[0]});
    wrap_up();
  end
endmodule : cts_top_bench
